// *** verilog/prs_ref_switch_div.sv ***
// Reference input control, revertive switchover, R divider and P/A/B feedback divider
//
// Contract
// RULE1: All reference inputs stay off after reset until explicitly enabled.
// RULE2: Reference select register chooses differential or two single-ended buffers.
// RULE3: Bias register bit 7 enables shifted bias on single-ended inputs.
// RULE4: Differential receiver off when not selected or loop powered down.
// RULE5: Single-ended buffer off on loop power-down, own disable, or differential mode.
// RULE6: Crystal amplifier on only while its enable bit is set.
// RULE7: Dual single-ended mode supports manual and automatic revertive selection.
// RULE8: Manual selection comes from register bit or the select pin.
// RULE9: Host ensures target reference toggles, or disables deglitching, before switching.
// RULE10: With 0xf7/0x26 programmed, monitor pin high selects second reference.
// RULE11: Deglitching blocks misaligned edges after a switch; bit 7 disables it.
// RULE12: Automatic switching always reverts to the first reference.
// RULE13: Reference divider is a 14-bit counter set by two registers.
// RULE14: Reference divider values zero and one both divide by one.
// RULE15: Reference divider reset by own bit, shared bit, or sync.
// RULE16: Feedback ratio is prescaler modulus times B plus A.
// RULE17: Prescaler offers fixed divide 1/2/3 and dual modulus P/P+1 modes.
// RULE18: Fixed-divide modes ignore the A counter.
// RULE19: Feedback ratios from 1 up to 262175 are reachable.
// RULE20: Host programs B at least 3 or bypasses it.
// RULE21: Host never programs A larger than B.
// RULE22: With B of 1 and A of 0 the divide equals the prescaler.
// RULE23: A/B reset and shared reset bits hold counters until cleared.
// RULE24: Sync pin resets R, A and B counters under sync control, off at reset.
// RULE25: Dividers count input rising edges; P+1 used while A count is unfinished.
`include "prs_consts.svh"
`default_nettype none

module prs_ref_switch_div
  import prs_pkg::*;
#(
  parameter int REF_TIMEOUT = `PRS_REF_TIMEOUT
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   clkEn,
  input  wire logic                   regWrEn,
  input  wire logic [`PRS_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWrData,
  output logic      [7:0]             regRdData,
  input  wire logic                   referencePinPair,
  input  wire logic                   firstReference,
  input  wire logic                   secondReference,
  input  wire logic                   refSelPin,
  input  wire logic                   syncPinN,
  input  wire logic                   vcoClkIn,
  output logic                        diffRxPowerDown,
  output logic                        firstRefPowerDown,
  output logic                        secondRefPowerDown,
  output logic                        crystalAmpEnable,
  output logic                        shiftedBiasEnable,
  output logic                        monitorPin,
  output logic                        refDivOut,
  output logic                        fbDivOut,
  output logic                        dualModulusCtl
);

  initial begin
    if (REF_TIMEOUT < 2 || REF_TIMEOUT > 65535) begin
      $error("REF_TIMEOUT out of range");
    end
  end

  localparam logic [15:0] TIMEOUT = 16'(REF_TIMEOUT);

  prs_state_type st_r;
  prs_state_type st_nxt;

  // Base modulus and dual-modulus flag for a prescaler mode
  function automatic logic [6:0] pscDecode(input logic [2:0] code);
    prs_psc_mode_type m;
    m = prs_psc_mode_type'(code);
    unique case (m)
      PSC_DM2:  pscDecode = {1'b1, 6'h02};
      PSC_DM4:  pscDecode = {1'b1, 6'h04};
      PSC_DM8:  pscDecode = {1'b1, 6'h08};
      PSC_DM16: pscDecode = {1'b1, 6'h10};
      PSC_DM32: pscDecode = {1'b1, 6'h20};
      PSC_FD1:  pscDecode = {1'b0, 6'h01};
      PSC_FD2:  pscDecode = {1'b0, 6'h02};
      PSC_FD3:  pscDecode = {1'b0, 6'h03};
    endcase
  endfunction

  logic        pllOff;
  logic        diffMode;
  logic        selRef2;
  logic        srcLevel;
  logic        refGated;
  logic        refEdge;
  logic        vcoEdge;
  logic        syncEdge;
  logic        rReset;
  logic        abReset;
  logic        ref1Bad;
  logic [6:0]  pscInfo;
  logic        dm;
  logic [5:0]  modulus;
  logic [5:0]  aEff;
  logic [12:0] bEff;
  logic [13:0] rEff;
  logic [7:0]  rdVal;

  // Derived controls
  always_comb begin
    pllOff   = st_r.pllPd != 2'h0;
    diffMode = st_r.selCtl[`PRS_SEL_DIFF];  // RULE2
    ref1Bad  = st_r.ref1Pd || (st_r.ref1Idle >= TIMEOUT);
    // Automatic mode reverts whenever the first reference is good again
    if (st_r.selCtl[`PRS_SEL_AUTO]) begin
      selRef2 = ref1Bad;  // RULE7 RULE10 RULE12
    end else if (st_r.selCtl[`PRS_SEL_USE_PIN]) begin
      selRef2 = refSelPin;  // RULE8
    end else begin
      selRef2 = st_r.selCtl[`PRS_SEL_MAN_SECOND_REFERENCE];  // RULE8
    end
    // Source feeding the R divider; a disabled path contributes nothing
    if (diffMode) begin
      srcLevel = referencePinPair && !st_r.diffPd;  // RULE1
    end else if (st_r.useRef2) begin
      srcLevel = secondReference && !st_r.ref2Pd;  // RULE1
    end else begin
      srcLevel = firstReference && !st_r.ref1Pd;  // RULE1
    end
    refGated = srcLevel && (st_r.gateOpen || diffMode);  // RULE11
    refEdge  = refGated && !st_r.refPrev;
    vcoEdge  = vcoClkIn && !st_r.vcoPrev;
    syncEdge = !syncPinN && st_r.syncPrev;
    rReset   = st_r.pscCtl[`PRS_PSC_R_RST] || st_r.pscCtl[`PRS_PSC_ALL_RST]  // RULE15
               || (syncEdge && (st_r.syncCtl == `PRS_SYNC_ALL
                                || st_r.syncCtl == `PRS_SYNC_R));  // RULE24
    abReset  = st_r.pscCtl[`PRS_PSC_AB_RST] || st_r.pscCtl[`PRS_PSC_ALL_RST]  // RULE23
               || (syncEdge && (st_r.syncCtl == `PRS_SYNC_ALL
                                || st_r.syncCtl == `PRS_SYNC_AB));  // RULE24
    pscInfo  = pscDecode(st_r.pscCtl[2:0]);  // RULE17
    dm       = pscInfo[6];
    aEff     = dm ? st_r.aVal : 6'h00;  // RULE18
    bEff     = (st_r.bVal == 13'h0000) ? 13'h0001 : st_r.bVal;  // RULE22
    rEff     = (st_r.rDiv < 14'h0002) ? 14'h0001 : st_r.rDiv;  // RULE14
    // P+1 while the A count is still running in this B cycle
    modulus  = (dm && st_r.aCount < aEff) ? pscInfo[5:0] + 6'h01 : pscInfo[5:0];  // RULE25
  end

  // Register read mux
  always_comb begin
    unique case (regAddr)
      `PRS_OFS_PLL_PD:  rdVal = {6'h00, st_r.pllPd};
      `PRS_OFS_RDIV_LO: rdVal = st_r.rDiv[7:0];
      `PRS_OFS_RDIV_HI: rdVal = {2'h0, st_r.rDiv[13:8]};
      `PRS_OFS_ACNT:    rdVal = {2'h0, st_r.aVal};
      `PRS_OFS_BCNT_LO: rdVal = st_r.bVal[7:0];
      `PRS_OFS_BCNT_HI: rdVal = {3'h0, st_r.bVal[12:8]};
      `PRS_OFS_PSC:     rdVal = st_r.pscCtl;
      `PRS_OFS_BIAS:    rdVal = st_r.biasCtl;
      `PRS_OFS_SYNC:    rdVal = {st_r.syncCtl, 6'h00};
      `PRS_OFS_MON:     rdVal = st_r.monCtl;
      `PRS_OFS_SEL:     rdVal = st_r.selCtl;
      `PRS_OFS_STATUS:  rdVal = {5'h00, st_r.gateOpen, ref1Bad, st_r.useRef2};
      default:          rdVal = 8'h00;
    endcase
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdData = rdVal;
    // Host writes
    if (regWrEn) begin
      unique case (regAddr)
        `PRS_OFS_PLL_PD:  st_nxt.pllPd = regWrData[1:0];
        `PRS_OFS_RDIV_LO: st_nxt.rDiv[7:0] = regWrData;  // RULE13
        `PRS_OFS_RDIV_HI: st_nxt.rDiv[13:8] = regWrData[5:0];  // RULE13
        `PRS_OFS_ACNT:    st_nxt.aVal = regWrData[5:0];
        `PRS_OFS_BCNT_LO: st_nxt.bVal[7:0] = regWrData;
        `PRS_OFS_BCNT_HI: st_nxt.bVal[12:8] = regWrData[4:0];
        `PRS_OFS_PSC:     st_nxt.pscCtl = regWrData;
        `PRS_OFS_BIAS:    st_nxt.biasCtl = regWrData;
        `PRS_OFS_SYNC:    st_nxt.syncCtl = regWrData[`PRS_SYNC_LSB+:2];
        `PRS_OFS_MON:     st_nxt.monCtl = regWrData;
        `PRS_OFS_SEL:     st_nxt.selCtl = regWrData;
        default: ;
      endcase
    end
    // Power and bias controls
    st_nxt.diffPd    = pllOff || !diffMode;  // RULE4
    st_nxt.ref1Pd    = pllOff || diffMode || !st_r.selCtl[`PRS_SEL_FIRST_REFERENCE_EN];  // RULE5
    st_nxt.ref2Pd    = pllOff || diffMode || !st_r.selCtl[`PRS_SEL_SECOND_REFERENCE_EN];  // RULE5
    st_nxt.xtalOn    = st_r.selCtl[`PRS_SEL_XTAL] && diffMode && !pllOff;  // RULE6
    st_nxt.shiftBias = st_r.biasCtl[`PRS_BIAS_SHIFT];  // RULE3
    st_nxt.monPin    = (st_r.monCtl == `PRS_MON_FIRST_REFERENCE_BAD) && ref1Bad;  // RULE10
    // First reference activity watchdog
    st_nxt.ref1Prev = firstReference;
    if (firstReference && !st_r.ref1Prev) begin
      st_nxt.ref1Idle = 16'h0000;
    end else if (st_r.ref1Idle < TIMEOUT) begin
      st_nxt.ref1Idle = st_r.ref1Idle + 16'h0001;
    end
    // Switchover with deglitch: wait for new reference low before passing edges
    if (selRef2 != st_r.useRef2) begin
      st_nxt.useRef2  = selRef2;
      st_nxt.gateOpen = st_r.selCtl[`PRS_SEL_NO_DEGL];  // RULE11 RULE9
    end else if (!st_r.gateOpen && !srcLevel) begin
      st_nxt.gateOpen = 1'b1;  // RULE11
    end
    st_nxt.refPrev  = refGated;
    st_nxt.syncPrev = !syncPinN;
    // Reference divider
    st_nxt.refDivOut = 1'b0;
    if (rReset) begin
      st_nxt.rCount = 14'h0000;  // RULE15
    end else if (refEdge) begin
      if (st_r.rCount + 14'h0001 >= rEff) begin
        st_nxt.rCount    = 14'h0000;
        st_nxt.refDivOut = 1'b1;  // RULE13
      end else begin
        st_nxt.rCount = st_r.rCount + 14'h0001;
      end
    end
    // Prescaler with A and B counters
    st_nxt.vcoPrev  = vcoClkIn;
    st_nxt.fbDivOut = 1'b0;
    if (abReset) begin
      st_nxt.pCount = 6'h00;  // RULE23
      st_nxt.bCount = 13'h0000;
      st_nxt.aCount = 6'h00;
    end else if (vcoEdge) begin
      if (st_r.pCount + 6'h01 >= modulus) begin
        st_nxt.pCount = 6'h00;
        if (st_r.bCount + 13'h0001 >= bEff) begin
          st_nxt.bCount   = 13'h0000;  // RULE16 RULE19
          st_nxt.aCount   = 6'h00;
          st_nxt.fbDivOut = 1'b1;
        end else begin
          st_nxt.bCount = st_r.bCount + 13'h0001;
          if (st_r.aCount < aEff) begin
            st_nxt.aCount = st_r.aCount + 6'h01;  // RULE25
          end
        end
      end else begin
        st_nxt.pCount = st_r.pCount + 6'h01;
      end
    end
    st_nxt.dmCtl = dm && (st_nxt.aCount < aEff);  // RULE25
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r         <= '0;
      st_r.pllPd   <= `PRS_PLL_PD_RST;
      st_r.pscCtl  <= `PRS_PSC_RST;
      st_r.selCtl  <= `PRS_SEL_RST;  // RULE1
      st_r.syncCtl <= `PRS_SYNC_RST;  // RULE24
      st_r.monCtl  <= `PRS_MON_RST;
      st_r.diffPd  <= 1'b1;
      st_r.ref1Pd  <= 1'b1;
      st_r.ref2Pd  <= 1'b1;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign regRdData          = st_r.rdData;
  assign diffRxPowerDown    = st_r.diffPd;
  assign firstRefPowerDown  = st_r.ref1Pd;
  assign secondRefPowerDown = st_r.ref2Pd;
  assign crystalAmpEnable   = st_r.xtalOn;
  assign shiftedBiasEnable  = st_r.shiftBias;
  assign monitorPin         = st_r.monPin;
  assign refDivOut          = st_r.refDivOut;
  assign fbDivOut           = st_r.fbDivOut;
  assign dualModulusCtl     = st_r.dmCtl;

endmodule
`default_nettype wire

// *** verilog/prs_consts.svh ***
// Register offsets, field positions, reset values and limits of the reference front end
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

`define PRS_ADDR_W        10
`define PRS_OFS_PLL_PD    10'h010
`define PRS_OFS_RDIV_LO   10'h011
`define PRS_OFS_RDIV_HI   10'h012
`define PRS_OFS_ACNT      10'h013
`define PRS_OFS_BCNT_LO   10'h014
`define PRS_OFS_BCNT_HI   10'h015
`define PRS_OFS_PSC       10'h016
`define PRS_OFS_BIAS      10'h018
`define PRS_OFS_SYNC      10'h019
`define PRS_OFS_MON       10'h01b
`define PRS_OFS_SEL       10'h01c
`define PRS_OFS_STATUS    10'h01f

`define PRS_PLL_PD_RST    2'h1
`define PRS_PSC_RST       8'h00
`define PRS_SEL_RST       8'h00
`define PRS_SYNC_RST      2'h0
`define PRS_MON_RST       8'h00
`define PRS_MON_FIRST_REFERENCE_BAD  8'hf7

// Prescaler control fields
`define PRS_PSC_R_RST     4
`define PRS_PSC_AB_RST    5
`define PRS_PSC_ALL_RST   6
// Bias register field
`define PRS_BIAS_SHIFT    7
// Sync control field and codes
`define PRS_SYNC_LSB      6
`define PRS_SYNC_ALL      2'h1
`define PRS_SYNC_AB       2'h2
`define PRS_SYNC_R        2'h3
// Reference select fields
`define PRS_SEL_DIFF      0
`define PRS_SEL_FIRST_REFERENCE_EN   1
`define PRS_SEL_SECOND_REFERENCE_EN   2
`define PRS_SEL_MAN_SECOND_REFERENCE  3
`define PRS_SEL_USE_PIN   4
`define PRS_SEL_AUTO      5
`define PRS_SEL_XTAL      6
`define PRS_SEL_NO_DEGL   7

`define PRS_REF_TIMEOUT   64

`endif

// *** verilog/prs_pkg.sv ***
// Types shared by the reference switch and divider block
`default_nettype none
package prs_pkg;

  typedef enum logic [2:0] {
    PSC_DM2, PSC_DM4, PSC_DM8, PSC_DM16, PSC_DM32, PSC_FD1, PSC_FD2, PSC_FD3
  } prs_psc_mode_type;

  typedef struct packed {
    logic [1:0]  pllPd;
    logic [13:0] rDiv;
    logic [5:0]  aVal;
    logic [12:0] bVal;
    logic [7:0]  pscCtl;
    logic [7:0]  biasCtl;
    logic [1:0]  syncCtl;
    logic [7:0]  monCtl;
    logic [7:0]  selCtl;
    logic        refPrev;
    logic        ref1Prev;
    logic        vcoPrev;
    logic        syncPrev;
    logic        useRef2;
    logic        gateOpen;
    logic [15:0] ref1Idle;
    logic [13:0] rCount;
    logic [5:0]  pCount;
    logic [12:0] bCount;
    logic [5:0]  aCount;
    logic        diffPd;
    logic        ref1Pd;
    logic        ref2Pd;
    logic        xtalOn;
    logic        shiftBias;
    logic        monPin;
    logic        refDivOut;
    logic        fbDivOut;
    logic        dmCtl;
    logic [7:0]  rdData;
  } prs_state_type;

endpackage
`default_nettype wire

// *** testbench/prs_ref_switch_div_assertions.sv ***
// Port-level checker of the reference switch and divider block
`include "prs_consts.svh"
`default_nettype none
module prs_ref_switch_div_assertions (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   clkEn,
  input wire logic                   regWrEn,
  input wire logic [`PRS_ADDR_W-1:0] regAddr,
  input wire logic [7:0]             regWrData,
  input wire logic [7:0]             regRdData,
  input wire logic                   diffRxPowerDown,
  input wire logic                   firstRefPowerDown,
  input wire logic                   secondRefPowerDown,
  input wire logic                   crystalAmpEnable,
  input wire logic                   shiftedBiasEnable,
  input wire logic                   monitorPin,
  input wire logic                   refDivOut,
  input wire logic                   fbDivOut,
  input wire logic                   dualModulusCtl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic loopOff_r, monF7_r, fdMode_r, wr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  assign wr = clkEn && regWrEn;
  // Expected path controls for a select value
  function automatic logic [3:0] selOut(input logic [7:0] d);
    return {!d[0], d[0] || !d[1], d[0] || !d[2], d[0] && d[6]};
  endfunction
  // Shadow of loop power-down, monitor code and prescaler family
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loopOff_r <= 1'b1;
      monF7_r <= 1'b0;
      fdMode_r <= 1'b0;
    end else if (wr && regAddr == `PRS_OFS_PLL_PD) begin
      loopOff_r <= (regWrData[1:0] != 2'h0);
    end else if (wr && regAddr == `PRS_OFS_MON) begin
      monF7_r <= (regWrData == `PRS_MON_FIRST_REFERENCE_BAD);
    end else if (wr && regAddr == `PRS_OFS_PSC) begin
      fdMode_r <= (regWrData[2:0] >= 3'h5);
    end
  end
  // Write steps followed by a running cycle
  sequence s_wr_sel;
    wr && regAddr == `PRS_OFS_SEL && !loopOff_r ##1 clkEn;
  endsequence
  sequence s_wr_bias;
    wr && regAddr == `PRS_OFS_BIAS ##1 clkEn;
  endsequence
  a_sel_paths: assert property (s_wr_sel |=>
    {diffRxPowerDown, firstRefPowerDown, secondRefPowerDown, crystalAmpEnable}
    == selOut($past(regWrData, 2))) else $error("path controls differ from select");
  a_xtal_diff: assert property (crystalAmpEnable |-> !diffRxPowerDown)
    else $error("crystal amp on without differential receiver");
  a_loop_off: assert property (loopOff_r && $past(loopOff_r) |->
    diffRxPowerDown && firstRefPowerDown && secondRefPowerDown && !crystalAmpEnable)
    else $error("reference path on while loop is off");
  a_reset_off: assert property (disable iff (1'b0) rst |=>
    diffRxPowerDown && firstRefPowerDown && secondRefPowerDown && !monitorPin)
    else $error("reference path on after reset");
  a_bias_bit: assert property (s_wr_bias |=>
    shiftedBiasEnable == ($past(regWrData, 2) >= 8'h80)) else $error("bias wrong");
  a_mon_code: assert property (monitorPin |-> $past(monF7_r))
    else $error("monitor high without its code");
  a_fd_no_dm: assert property (fdMode_r && $past(fdMode_r) && $past(fdMode_r, 2) |->
    !dualModulusCtl) else $error("modulus control in fixed mode");
  a_ref_pulse: assert property (refDivOut && clkEn |=> !refDivOut)
    else $error("reference pulse too long");
  a_fb_pulse: assert property (fbDivOut && clkEn |=> !fbDivOut)
    else $error("feedback pulse too long");
  a_rdiv_width: assert property (clkEn && regAddr == `PRS_OFS_RDIV_HI |=>
    regRdData[7:6] == 2'h0) else $error("divider high byte too wide");
endmodule
bind prs_ref_switch_div prs_ref_switch_div_assertions chk (
  .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regWrEn(regWrEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .diffRxPowerDown(diffRxPowerDown),
  .firstRefPowerDown(firstRefPowerDown), .secondRefPowerDown(secondRefPowerDown),
  .crystalAmpEnable(crystalAmpEnable), .shiftedBiasEnable(shiftedBiasEnable),
  .monitorPin(monitorPin), .refDivOut(refDivOut), .fbDivOut(fbDivOut),
  .dualModulusCtl(dualModulusCtl));
`default_nettype wire

// *** testbench/prs_ref_source.sv ***
// Reference sources and oscillator clock driven toward the block
`default_nettype none
module prs_ref_source (
  input  wire logic            sys_clk,
  input  wire logic [3:0][7:0] halfPer,
  output logic      [3:0]      level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0][7:0] cnt_r;
  // Each source toggles every halfPer cycles; zero stops it low
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (halfPer[i] == 8'h00) begin
        cnt_r[i] <= 8'h00;
        level[i] <= 1'b0;
      end else if (cnt_r[i] + 8'h01 >= halfPer[i]) begin
        cnt_r[i] <= 8'h00;
        level[i] <= !level[i];
      end else begin
        cnt_r[i] <= cnt_r[i] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_prs_ref_switch_div.sv ***
// Self-checking bench of the reference switch and divider block
`include "prs_consts.svh"
`default_nettype none
module tb_prs_ref_switch_div import prs_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {prs_psc_mode_type m; logic [12:0] b; logic [5:0] a; int n;
    logic [13:0] r; int rr;} prs_row_type;
  logic            sys_clk, rst, clkEn, regWrEn, refSelPin, syncPinN;
  logic [9:0]      regAddr;
  logic [7:0]      regWrData, regRdData, v;
  logic [3:0][7:0] halfPer;
  logic [3:0]      srcLvl;
  logic            diffPd, ref1Pd, ref2Pd, xtalEn, biasEn, monPin, refDiv, fbDiv, dmCtl;
  int              n_mismatch, compares, cycles;
  prs_row_type     rows [8] = '{
    '{PSC_FD1, 13'h1, 6'h0, 1, 14'h0, 1},
    '{PSC_FD2, 13'h1, 6'h0, 2, 14'h1, 1},
    '{PSC_FD3, 13'h6, 6'h5, 18, 14'h2, 2},
    '{PSC_DM2, 13'h3, 6'h1, 7, 14'h3, 3},
    '{PSC_DM4, 13'h3, 6'h2, 14, 14'h5, 5},
    '{PSC_DM8, 13'h12, 6'h7, 151, 14'h105, 261},
    '{PSC_DM16, 13'h9, 6'h7, 151, 14'h7, 7},
    '{PSC_DM32, 13'h3, 6'h3, 99, 14'h4, 4}};
  prs_ref_switch_div #(.REF_TIMEOUT(8)) uut (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .referencePinPair(srcLvl[3]),
    .firstReference(srcLvl[0]), .secondReference(srcLvl[1]), .refSelPin(refSelPin),
    .syncPinN(syncPinN), .vcoClkIn(srcLvl[2]), .diffRxPowerDown(diffPd),
    .firstRefPowerDown(ref1Pd), .secondRefPowerDown(ref2Pd), .crystalAmpEnable(xtalEn),
    .shiftedBiasEnable(biasEn), .monitorPin(monPin), .refDivOut(refDiv),
    .fbDivOut(fbDiv), .dualModulusCtl(dmCtl));
  prs_ref_source src (.sys_clk(sys_clk), .halfPer(halfPer), .level(srcLvl));
  // Clock and hang guard
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  // One write, then two idle cycles so the strobe drops cleanly
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    tick(2);
  endtask
  task automatic rd(input logic [9:0] a);
    regAddr = a;
    tick(1);
    v = regRdData;
  endtask
  // Cycles between two successive pulses of one divider
  task automatic period(input logic fb, input int exp);
    int n = 0;
    int k = 0;
    while (k < 2) begin
      tick(1);
      n = (k == 0) ? 0 : n + 1;
      if ((fb ? fbDiv : refDiv) === 1'b1) k++;
    end
    chk(fb ? "fb period" : "ref period", exp, n);
  endtask
  task automatic quiet(input logic fb, input int n);
    int p = 0;
    repeat (n) begin
      tick(1);
      if ((fb ? fbDiv : refDiv) !== 1'b0) p++;
    end
    chk("pulses", 0, p);
  endtask
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    regWrEn = 1'b0;
    regAddr = 10'h000;
    regWrData = 8'h00;
    refSelPin = 1'b0;
    syncPinN = 1'b1;
    halfPer = '0;
    tick(4);
    rst = 1'b0;
    chk("pd after reset", 9'h1c0, {diffPd, ref1Pd, ref2Pd, xtalEn, biasEn, monPin,
      refDiv, fbDiv, dmCtl});
    rd(`PRS_OFS_SYNC);
    chk("sync ctl", 8'h00, v);
    $display("test reset done");
    halfPer = {8'h2, 8'h1, 8'h3, 8'h2};
    wr(`PRS_OFS_PLL_PD, 8'h00);
    wr(`PRS_OFS_SEL, 8'h06);
    for (int i = 0; i < 8; i++) begin
      wr(`PRS_OFS_PSC, 8'h40 | 8'(rows[i].m));
      wr(`PRS_OFS_RDIV_LO, rows[i].r[7:0]);
      wr(`PRS_OFS_RDIV_HI, {2'h0, rows[i].r[13:8]});
      wr(`PRS_OFS_ACNT, {2'h0, rows[i].a});
      wr(`PRS_OFS_BCNT_LO, rows[i].b[7:0]);
      wr(`PRS_OFS_BCNT_HI, {3'h0, rows[i].b[12:8]});
      wr(`PRS_OFS_PSC, 8'(rows[i].m));
      period(1'b1, 2 * rows[i].n);
      period(1'b0, 4 * rows[i].rr);
    end
    $display("test ratio table done");
    wr(`PRS_OFS_PSC, 8'h24);
    quiet(1'b1, 400);
    rd(`PRS_OFS_PSC);
    chk("psc hold", 8'h24, v);
    wr(`PRS_OFS_PSC, 8'h14);
    quiet(1'b0, 100);
    wr(`PRS_OFS_PSC, 8'h04);
    period(1'b1, 198);
    // Freeze only between reference pulses so no pulse is held
    while (refDiv !== 1'b0) tick(1);
    clkEn = 1'b0;
    quiet(1'b0, 40);
    clkEn = 1'b1;
    wr(`PRS_OFS_BIAS, 8'h80);
    chk("bias", 1, biasEn);
    $display("test resets and bias done");
    wr(`PRS_OFS_MON, 8'hf7);
    wr(`PRS_OFS_SEL, 8'h26);
    halfPer[0] = 8'h0;
    tick(30);
    rd(`PRS_OFS_STATUS);
    chk("first_reference lost", 3'h7, {monPin, v[1:0]});
    period(1'b0, 24);
    halfPer[0] = 8'h2;
    tick(30);
    rd(`PRS_OFS_STATUS);
    chk("first_reference back", 3'h0, {monPin, v[1:0]});
    $display("test automatic switch done");
    wr(`PRS_OFS_MON, 8'h00);
    wr(`PRS_OFS_SEL, 8'h16);
    refSelPin = 1'b1;
    tick(4);
    rd(`PRS_OFS_STATUS);
    chk("pin select", 1, v[0]);
    wr(`PRS_OFS_SEL, 8'h06);
    halfPer[1] = 8'h0;
    wr(`PRS_OFS_SEL, 8'h0e);
    halfPer[0] = 8'h0;
    tick(30);
    rd(`PRS_OFS_STATUS);
    chk("stopped low opens", 3'h3, {monPin, v[2], v[0]});
    halfPer = {8'h2, 8'h1, 8'h3, 8'h2};
    tick(20);
    rd(`PRS_OFS_STATUS);
    chk("gate open", 1, v[2]);
    $display("test manual switch done");
    wr(`PRS_OFS_SEL, 8'h41);
    chk("diff paths", 4'h7, {diffPd, ref1Pd, ref2Pd, xtalEn});
    period(1'b0, 16);
    wr(`PRS_OFS_PLL_PD, 8'h01);
    chk("loop off", 4'he, {diffPd, ref1Pd, ref2Pd, xtalEn});
    rd(10'h3f0);
    chk("unmapped", 8'h00, v);
    wr(`PRS_OFS_SYNC, 8'hc0);
    rd(`PRS_OFS_SYNC);
    chk("sync ctl set", 8'hc0, v);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    chk("second reset", 3'h7, {diffPd, ref1Pd, ref2Pd});
    $display("test paths and reset done");
    stop_test();
  end
endmodule
`default_nettype wire
